//--- logic/clcc_regs.vh
// constants of the closed loop cascade controller
`ifndef CLCC_REGS_VH
`define CLCC_REGS_VH
`define CLCC_MODE_PP        4'h1
`define CLCC_MODE_VEL       4'h2
`define CLCC_MODE_PV        4'h3
`define CLCC_MODE_PT        4'h4
`define CLCC_MODE_HM        4'h6
`define CLCC_MODE_IP        4'h7
`define CLCC_MODE_CSP       4'h8
`define CLCC_MODE_CSV       4'h9
`define CLCC_MODE_CST       4'hA
`define CLCC_MODE_CD        4'hF
`define CLCC_SUB_CLOSED     0
`define CLCC_SUB_POSLOOP    1
`define CLCC_SUB_REALTRQ    5
`define CLCC_GW             16
`define CLCC_GAINS_W        128
`define CLCC_STG_IQ         0
`define CLCC_STG_ID         1
`define CLCC_STG_VEL        2
`define CLCC_STG_POS        3
`define CLCC_GAIN_RST       128'h0
`define CLCC_FF_RST         16'h0000
`define CLCC_VOLT_FF_RST    16'h03E8
`define CLCC_PERMILLE       64'sh3E8
`define CLCC_NS_PER_US      64'sh3E8
`define CLCC_CLK_NS         5
`define CLCC_UPDATE_NS      50000
`define CLCC_PSHIFT         10
`define CLCC_INERTIA_SHIFT  8
`endif

//--- logic/clcc_pi_stage.v
// one saturating proportional-integral stage of the cascade
`timescale 1ns/100ps
`include "clcc_regs.vh"
module clcc_pi_stage #(
  parameter W       = 24,
  parameter GW      = 16,
  parameter TICK_NS = 50000
) (
  input  wire                clk,
  input  wire                rst_n,
  input  wire                tick,
  input  wire                enable,
  input  wire signed [W-1:0] setpoint,
  input  wire signed [W-1:0] actual,
  input  wire [GW-1:0]       kp,
  input  wire [GW-1:0]       ti,
  input  wire [W-2:0]        limit,
  output reg  signed [W-1:0] out_r
);
  localparam AW = 64;
  localparam signed [AW-1:0] TICK_X = TICK_NS;

  reg  signed [AW-1:0] acc_r;
  reg  signed [AW-1:0] acc_nxt;
  reg  signed [AW-1:0] out_nxt;

  wire signed [W:0]    err   = {setpoint[W-1], setpoint} - {actual[W-1], actual};
  wire signed [AW-1:0] err_x = {{(AW-W-1){err[W]}}, err};
  wire signed [AW-1:0] kp_x  = {{(AW-GW){1'b0}}, kp};
  wire signed [AW-1:0] ti_x  = {{(AW-GW){1'b0}}, ti};
  wire signed [AW-1:0] lim_x = {{(AW-W+1){1'b0}}, limit};
  wire signed [AW-1:0] prod  = err_x * kp_x; // [RQ6]
  wire signed [AW-1:0] lim_s = lim_x <<< `CLCC_PSHIFT;

  function signed [AW-1:0] clamp;
    input signed [AW-1:0] v;
    input signed [AW-1:0] lim;
    begin
      if (v > lim)
        clamp = lim;
      else if (v < -lim)
        clamp = -lim;
      else
        clamp = v;
    end
  endfunction

  always @* begin
    if (ti == {GW{1'b0}})
      acc_nxt = {AW{1'b0}}; // [RQ7]
    else
      // one tick of the integrator shrinks as ti grows [RQ8]
      acc_nxt = clamp(acc_r + (prod * TICK_X) / (ti_x * `CLCC_NS_PER_US), lim_s);
    out_nxt = clamp((prod + acc_nxt) >>> `CLCC_PSHIFT, lim_x); // [RQ5]
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_r <= {AW{1'b0}};
      out_r <= {W{1'b0}};
    end else if (!enable) begin
      acc_r <= {AW{1'b0}};
      out_r <= {W{1'b0}};
    end else if (tick) begin
      // gains are read live, so a change acts next tick on the kept state [RQ19]
      acc_r <= acc_nxt;
      out_r <= out_nxt[W-1:0];
    end
  end
endmodule

//--- logic/clcc_cascade.v
// position, velocity and current cascade with feed-forward paths
`timescale 1ns/100ps
`include "clcc_regs.vh"
// How it works
// [RQ1] position feeds velocity feeds current; each output is the next set point
// [RQ2] current stage runs in every mode while closed loop is on
// [RQ3] velocity stage runs except torque modes with submode bit 5 set
// [RQ4] position stage in position modes, and velocity modes with submode bit 1
// [RQ5] outputs clamp at max speed, max current and max PWM respectively
// [RQ6] proportional part is error times proportional gain
// [RQ7] integrator time zero clears the integral part, leaving pure proportional
// [RQ8] integral step is inversely proportional to integrator time
// [RQ9] current stage has own gain and time for torque and field parts
// [RQ10] velocity gain in mA/Hz, position gain in Hz, times in microseconds
// [RQ11] legacy gains after reset; selecting set one copies legacy into new set
// [RQ12] velocity feed-forward is ramp velocity times permille factor, added before velocity
// [RQ13] velocity feed-forward only in modes that close the position loop
// [RQ14] acceleration feed-forward is factor times inertia times ramp acceleration
// [RQ15] acceleration feed-forward in every mode except torque modes
// [RQ16] voltage feed-forward is permille of rated voltage, default full scale
// [RQ17] voltage feed-forward always active, off when its factor is zero
// [RQ18] closed loop only with submode bit 0 set, else open loop
// [RQ19] setting changes act from the next update without clearing stage state
module clcc_cascade #(
  parameter W             = 24,
  parameter UPDATE_CYCLES = `CLCC_UPDATE_NS / `CLCC_CLK_NS
) (
  input  wire                       CLK,
  input  wire                       RST_N,
  input  wire [3:0]                 MODE,
  input  wire [15:0]                SUBMODE,
  input  wire signed [W-1:0]        TARGET_POS,
  input  wire signed [W-1:0]        TARGET_TORQUE,
  input  wire signed [W-1:0]        RAMP_VEL,
  input  wire signed [W-1:0]        RAMP_ACC,
  input  wire signed [W-1:0]        ACT_POS,
  input  wire signed [W-1:0]        ACT_VEL,
  input  wire signed [W-1:0]        ACT_IQ,
  input  wire signed [W-1:0]        ACT_ID,
  input  wire [W-2:0]               MAX_SPEED,
  input  wire [W-2:0]               MAX_CURRENT,
  input  wire [W-2:0]               MAX_PWM,
  input  wire [W-2:0]               RATED_VOLT,
  input  wire [15:0]                INERTIA,
  input  wire [`CLCC_GAINS_W-1:0]   GAIN_LEGACY,
  input  wire [`CLCC_GAINS_W-1:0]   GAIN_NEW,
  input  wire                       GAIN_WR,
  input  wire                       SET_SEL_WR,
  input  wire                       SET_SEL_DATA,
  input  wire [15:0]                VEL_FF_FACTOR,
  input  wire [15:0]                ACC_FF_FACTOR,
  input  wire [15:0]                VOLT_FF_FACTOR,
  input  wire                       FF_WR,
  output reg  signed [W-1:0]        PWM_Q,
  output reg  signed [W-1:0]        PWM_D,
  output reg  signed [W-1:0]        VEL_SETPOINT,
  output reg  signed [W-1:0]        CUR_SETPOINT,
  output reg                        CLOSED_LOOP,
  output reg                        POS_ACTIVE,
  output reg                        VEL_ACTIVE,
  output reg                        NEW_SET_ACTIVE,
  output reg                        UPDATE_TICK
);
  localparam AW      = 64;
  localparam GW      = `CLCC_GW;
  localparam TICK_NS = UPDATE_CYCLES * `CLCC_CLK_NS;

  // mode classification, shared by several enables
  function is_pos_mode;
    input [3:0] m;
    begin
      is_pos_mode = (m == `CLCC_MODE_PP) || (m == `CLCC_MODE_HM) ||
                    (m == `CLCC_MODE_IP) || (m == `CLCC_MODE_CSP) ||
                    (m == `CLCC_MODE_CD);
    end
  endfunction

  function is_torque_mode;
    input [3:0] m;
    begin
      is_torque_mode = (m == `CLCC_MODE_PT) || (m == `CLCC_MODE_CST);
    end
  endfunction

  function signed [AW-1:0] sat;
    input signed [AW-1:0] v;
    input [W-2:0]         lim;
    reg   signed [AW-1:0] l;
    begin
      l = {{(AW-W+1){1'b0}}, lim};
      if (v > l)
        sat = l;
      else if (v < -l)
        sat = -l;
      else
        sat = v;
    end
  endfunction

  // update-rate divider
  reg  [31:0] div_r;
  wire        tick = (div_r == UPDATE_CYCLES - 1);

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N)
      div_r <= 32'h0;
    else if (tick)
      div_r <= 32'h0;
    else
      div_r <= div_r + 32'h1;
  end

  // gain set selection and the new gain set
  reg                      set_sel_r;
  reg  [`CLCC_GAINS_W-1:0] gain_new_r;

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      set_sel_r  <= 1'b0; // [RQ11]
      gain_new_r <= `CLCC_GAIN_RST;
    end else if (SET_SEL_WR) begin
      set_sel_r <= SET_SEL_DATA;
      if (SET_SEL_DATA && !set_sel_r)
        gain_new_r <= GAIN_LEGACY; // [RQ11]
    end else if (GAIN_WR && set_sel_r) begin
      gain_new_r <= GAIN_NEW;
    end
  end

  wire [`CLCC_GAINS_W-1:0] gain_eff = set_sel_r ? gain_new_r : GAIN_LEGACY;
  wire [4*GW-1:0]          kp_all;
  wire [4*GW-1:0]          ti_all;

  // field 2s is the gain of stage s, field 2s+1 its integrator time [RQ9] [RQ10]
  genvar s;
  generate
    for (s = 0; s < 4; s = s + 1) begin : g_gain
      assign kp_all[s*GW +: GW] = gain_eff[(2*s)*GW +: GW];
      assign ti_all[s*GW +: GW] = gain_eff[(2*s+1)*GW +: GW];
    end
  endgenerate

  // feed-forward factors; full-scale voltage factor after reset
  reg [15:0] vel_ff_r;
  reg [15:0] acc_ff_r;
  reg [15:0] volt_ff_r;

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      vel_ff_r  <= `CLCC_FF_RST;
      acc_ff_r  <= `CLCC_FF_RST;
      volt_ff_r <= `CLCC_VOLT_FF_RST; // [RQ16]
    end else if (FF_WR) begin
      vel_ff_r  <= VEL_FF_FACTOR;
      acc_ff_r  <= ACC_FF_FACTOR;
      volt_ff_r <= VOLT_FF_FACTOR;
    end
  end

  // stage enables
  wire closed  = SUBMODE[`CLCC_SUB_CLOSED]; // [RQ18]
  wire torque  = is_torque_mode(MODE);
  wire velmode = (MODE == `CLCC_MODE_VEL) || (MODE == `CLCC_MODE_PV);
  wire cur_en  = closed; // [RQ2]
  wire vel_en  = closed && !(torque && SUBMODE[`CLCC_SUB_REALTRQ]); // [RQ3]
  wire pos_en  = closed && (is_pos_mode(MODE) ||
                 ((velmode || MODE == `CLCC_MODE_CSV) &&
                  SUBMODE[`CLCC_SUB_POSLOOP])); // [RQ4]
  wire vff_en  = closed && (is_pos_mode(MODE) ||
                 (velmode && SUBMODE[`CLCC_SUB_POSLOOP])); // [RQ13]
  wire aff_en  = closed && !torque; // [RQ15]

  // feed-forward terms
  wire signed [AW-1:0] rv_x = {{(AW-W){RAMP_VEL[W-1]}}, RAMP_VEL};
  wire signed [AW-1:0] ra_x = {{(AW-W){RAMP_ACC[W-1]}}, RAMP_ACC};
  wire signed [AW-1:0] vf_x = {{(AW-16){1'b0}}, vel_ff_r};
  wire signed [AW-1:0] af_x = {{(AW-16){1'b0}}, acc_ff_r};
  wire signed [AW-1:0] in_x = {{(AW-16){1'b0}}, INERTIA};
  wire signed [AW-1:0] uf_x = {{(AW-16){1'b0}}, volt_ff_r};
  wire signed [AW-1:0] rt_x = {{(AW-W+1){1'b0}}, RATED_VOLT};

  wire signed [AW-1:0] vff  = vff_en ? (rv_x * vf_x) / `CLCC_PERMILLE
                                     : {AW{1'b0}}; // [RQ12]
  wire signed [AW-1:0] aff  = aff_en ? ((ra_x * in_x * af_x) / `CLCC_PERMILLE)
                                       >>> `CLCC_INERTIA_SHIFT
                                     : {AW{1'b0}}; // [RQ14]
  // a zero factor gives a zero term, which is the off switch [RQ17]
  wire signed [AW-1:0] uff  = (rt_x * uf_x) / `CLCC_PERMILLE; // [RQ16]

  // stage outputs and the set points they form
  wire signed [W-1:0] pos_out;
  wire signed [W-1:0] vel_out;
  wire signed [W-1:0] iq_out;
  wire signed [W-1:0] id_out;

  wire signed [AW-1:0] pos_x = {{(AW-W){pos_out[W-1]}}, pos_out};
  wire signed [AW-1:0] vel_x = {{(AW-W){vel_out[W-1]}}, vel_out};
  wire signed [AW-1:0] iq_x  = {{(AW-W){iq_out[W-1]}}, iq_out};
  wire signed [AW-1:0] tt_x  = {{(AW-W){TARGET_TORQUE[W-1]}}, TARGET_TORQUE};

  // without a position loop the ramp velocity is the velocity set point
  wire signed [AW-1:0] vel_sp_x = pos_en ? sat(pos_x + vff, MAX_SPEED)
                                         : sat(rv_x, MAX_SPEED); // [RQ1] [RQ12]
  // with the velocity stage off, the torque target drives current directly
  wire signed [AW-1:0] cur_sp_x = vel_en ? sat(vel_x + aff, MAX_CURRENT)
                                         : sat(tt_x, MAX_CURRENT); // [RQ1] [RQ14]
  wire signed [AW-1:0] pwm_q_x  = sat(iq_x + uff, MAX_PWM); // [RQ5]

  wire signed [W-1:0] vel_sp = vel_sp_x[W-1:0];
  wire signed [W-1:0] cur_sp = cur_sp_x[W-1:0];

  clcc_pi_stage #(.W(W), .GW(GW), .TICK_NS(TICK_NS)) u_pos (
    .clk      (CLK),
    .rst_n    (RST_N),
    .tick     (tick),
    .enable   (pos_en),
    .setpoint (TARGET_POS),
    .actual   (ACT_POS),
    .kp       (kp_all[`CLCC_STG_POS*GW +: GW]),
    .ti       (ti_all[`CLCC_STG_POS*GW +: GW]),
    .limit    (MAX_SPEED),
    .out_r    (pos_out)
  );

  clcc_pi_stage #(.W(W), .GW(GW), .TICK_NS(TICK_NS)) u_vel (
    .clk      (CLK),
    .rst_n    (RST_N),
    .tick     (tick),
    .enable   (vel_en),
    .setpoint (vel_sp),
    .actual   (ACT_VEL),
    .kp       (kp_all[`CLCC_STG_VEL*GW +: GW]),
    .ti       (ti_all[`CLCC_STG_VEL*GW +: GW]),
    .limit    (MAX_CURRENT),
    .out_r    (vel_out)
  );

  clcc_pi_stage #(.W(W), .GW(GW), .TICK_NS(TICK_NS)) u_iq (
    .clk      (CLK),
    .rst_n    (RST_N),
    .tick     (tick),
    .enable   (cur_en),
    .setpoint (cur_sp),
    .actual   (ACT_IQ),
    .kp       (kp_all[`CLCC_STG_IQ*GW +: GW]),
    .ti       (ti_all[`CLCC_STG_IQ*GW +: GW]),
    .limit    (MAX_PWM),
    .out_r    (iq_out)
  );

  // field current is regulated toward zero
  clcc_pi_stage #(.W(W), .GW(GW), .TICK_NS(TICK_NS)) u_id (
    .clk      (CLK),
    .rst_n    (RST_N),
    .tick     (tick),
    .enable   (cur_en),
    .setpoint ({W{1'b0}}),
    .actual   (ACT_ID),
    .kp       (kp_all[`CLCC_STG_ID*GW +: GW]),
    .ti       (ti_all[`CLCC_STG_ID*GW +: GW]),
    .limit    (MAX_PWM),
    .out_r    (id_out)
  );

  // registered outputs; open loop drives no closed-loop demand
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PWM_Q          <= {W{1'b0}};
      PWM_D          <= {W{1'b0}};
      VEL_SETPOINT   <= {W{1'b0}};
      CUR_SETPOINT   <= {W{1'b0}};
      CLOSED_LOOP    <= 1'b0;
      POS_ACTIVE     <= 1'b0;
      VEL_ACTIVE     <= 1'b0;
      NEW_SET_ACTIVE <= 1'b0;
      UPDATE_TICK    <= 1'b0;
    end else begin
      CLOSED_LOOP    <= closed; // [RQ18]
      POS_ACTIVE     <= pos_en;
      VEL_ACTIVE     <= vel_en;
      NEW_SET_ACTIVE <= set_sel_r;
      UPDATE_TICK    <= tick;
      if (!closed) begin
        PWM_Q        <= {W{1'b0}}; // [RQ18]
        PWM_D        <= {W{1'b0}};
        VEL_SETPOINT <= {W{1'b0}};
        CUR_SETPOINT <= {W{1'b0}};
      end else begin
        PWM_Q        <= pwm_q_x[W-1:0]; // [RQ17]
        PWM_D        <= id_out;
        VEL_SETPOINT <= vel_sp;
        CUR_SETPOINT <= cur_sp;
      end
    end
  end
endmodule

//--- bench/clcc_cascade_chk.sv
// port-level assertions for the cascade controller
`timescale 1ns/100ps
`include "clcc_regs.vh"
module clcc_cascade_chk #(
  parameter W             = 24,
  parameter UPDATE_CYCLES = 8
) (
  input wire                CLK,
  input wire                RST_N,
  input wire [3:0]          MODE,
  input wire [15:0]         SUBMODE,
  input wire [W-2:0]        MAX_SPEED,
  input wire [W-2:0]        MAX_CURRENT,
  input wire [W-2:0]        MAX_PWM,
  input wire signed [W-1:0] PWM_Q,
  input wire signed [W-1:0] PWM_D,
  input wire signed [W-1:0] VEL_SETPOINT,
  input wire signed [W-1:0] CUR_SETPOINT,
  input wire                CLOSED_LOOP,
  input wire                POS_ACTIVE,
  input wire                VEL_ACTIVE,
  input wire                UPDATE_TICK
);
  wire       trq = (MODE == `CLCC_MODE_PT) || (MODE == `CLCC_MODE_CST);
  wire       vmode = (MODE == `CLCC_MODE_VEL) || (MODE == `CLCC_MODE_PV) ||
                     (MODE == `CLCC_MODE_CSV);
  wire       pmode = (MODE == `CLCC_MODE_PP) || (MODE == `CLCC_MODE_HM) ||
                     (MODE == `CLCC_MODE_IP) || (MODE == `CLCC_MODE_CSP) ||
                     (MODE == `CLCC_MODE_CD) || (vmode && SUBMODE[1]);
  reg [15:0] gap_r;
  function lim_ok(input signed [W-1:0] v, input [W-2:0] m);
    lim_ok = (v <= $signed({1'b0, m})) && (v >= -$signed({1'b0, m}));
  endfunction
  // gap counts cycles since the last tick; zero until the first one
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N)
      gap_r <= 16'h0000;
    else if (UPDATE_TICK)
      gap_r <= 16'h0001;
    else if (gap_r != 16'h0000)
      gap_r <= gap_r + 16'h0001;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_closed_follow: assert property (1'b1 |=> CLOSED_LOOP == $past(SUBMODE[0]))
    else $error("closed loop flag does not follow submode");
  a_open_quiet: assert property ((!SUBMODE[0]) [*3] |-> PWM_Q == 0 && PWM_D == 0 &&
    VEL_SETPOINT == 0 && CUR_SETPOINT == 0) else $error("demand not zero in open loop");
  a_vel_off: assert property (SUBMODE[0] && SUBMODE[5] && trq |=> !VEL_ACTIVE)
    else $error("velocity stage on in real torque mode");
  a_vel_on: assert property (SUBMODE[0] && !(SUBMODE[5] && trq) |=> VEL_ACTIVE)
    else $error("velocity stage off outside real torque");
  a_pos_select: assert property (SUBMODE[0] |=> POS_ACTIVE == $past(pmode))
    else $error("position stage enable wrong for mode");
  a_speed_clamp: assert property (lim_ok(VEL_SETPOINT, MAX_SPEED))
    else $error("velocity set point beyond max speed");
  a_current_clamp: assert property (lim_ok(CUR_SETPOINT, MAX_CURRENT))
    else $error("current set point beyond max current");
  a_pwm_clamp: assert property (lim_ok(PWM_Q, MAX_PWM) && lim_ok(PWM_D, MAX_PWM))
    else $error("pwm demand beyond max pwm");
  a_update_period: assert property (gap_r != 0 |-> gap_r <= UPDATE_CYCLES &&
    UPDATE_TICK == (gap_r == UPDATE_CYCLES)) else $error("control update period wrong");
endmodule
bind clcc_cascade clcc_cascade_chk #(.W(W), .UPDATE_CYCLES(UPDATE_CYCLES)) i_chk (
  .CLK(CLK), .RST_N(RST_N), .MODE(MODE), .SUBMODE(SUBMODE), .MAX_SPEED(MAX_SPEED),
  .MAX_CURRENT(MAX_CURRENT), .MAX_PWM(MAX_PWM), .PWM_Q(PWM_Q), .PWM_D(PWM_D),
  .VEL_SETPOINT(VEL_SETPOINT), .CUR_SETPOINT(CUR_SETPOINT), .CLOSED_LOOP(CLOSED_LOOP),
  .POS_ACTIVE(POS_ACTIVE), .VEL_ACTIVE(VEL_ACTIVE), .UPDATE_TICK(UPDATE_TICK));

//--- bench/clcc_motor_model.sv
// behavioural power stage and rotor feedback
`timescale 1ns/100ps
module clcc_motor_model #(
  parameter W = 24
) (
  input  wire                CLK,
  input  wire                RST_N,
  input  wire                LIVE,
  input  wire signed [W-1:0] PWM_Q,
  input  wire signed [W-1:0] PWM_D,
  output reg  signed [W-1:0] ACT_POS,
  output reg  signed [W-1:0] ACT_VEL,
  output reg  signed [W-1:0] ACT_IQ,
  output reg  signed [W-1:0] ACT_ID
);
  // held at zero when not live, so bench sums stay exact
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N || !LIVE) begin
      ACT_POS <= '0;
      ACT_VEL <= '0;
      ACT_IQ  <= '0;
      ACT_ID  <= '0;
    end else begin
      ACT_IQ  <= ACT_IQ + ((PWM_Q - ACT_IQ) >>> 3);
      ACT_ID  <= ACT_ID + ((PWM_D - ACT_ID) >>> 3);
      ACT_VEL <= ACT_VEL + ((ACT_IQ - ACT_VEL) >>> 4);
      ACT_POS <= ACT_POS + (ACT_VEL >>> 6);
    end
  end
endmodule

//--- bench/clcc_cascade_tb.sv
// self-checking bench for the cascade controller
`timescale 1ns/100ps
`include "clcc_regs.vh"
module clcc_cascade_tb;
  localparam W = 24;
  reg                CLK, RST_N, GAIN_WR, SET_SEL_WR, SET_SEL_DATA, FF_WR, live;
  reg [3:0]          MODE;
  reg [15:0]         SUBMODE, INERTIA, VEL_FF_FACTOR, ACC_FF_FACTOR, VOLT_FF_FACTOR;
  reg signed [W-1:0] TARGET_POS, TARGET_TORQUE, RAMP_VEL, RAMP_ACC;
  reg [W-2:0]        MAX_SPEED, MAX_CURRENT, MAX_PWM, RATED_VOLT;
  reg [127:0]        GAIN_LEGACY, GAIN_NEW;
  wire signed [W-1:0] ACT_POS, ACT_VEL, ACT_IQ, ACT_ID, PWM_Q, PWM_D, VEL_SETPOINT, CUR_SETPOINT;
  wire               CLOSED_LOOP, POS_ACTIVE, VEL_ACTIVE, NEW_SET_ACTIVE, UPDATE_TICK;
  integer            bad_count, n_checks, cyc, i, v1, pk, vk, vf, af, uf;
  // mode, submode low byte, then expected closed, position, velocity flags
  reg [14:0] rows [0:15] = '{{4'h1, 8'h01, 3'h7}, {4'h1, 8'h00, 3'h0}, {4'h2, 8'h01, 3'h5},
    {4'h2, 8'h03, 3'h7}, {4'h3, 8'h03, 3'h7}, {4'h4, 8'h01, 3'h5}, {4'h4, 8'h21, 3'h4},
    {4'h4, 8'h23, 3'h4}, {4'h6, 8'h01, 3'h7}, {4'h7, 8'h01, 3'h7}, {4'h8, 8'h01, 3'h7},
    {4'h9, 8'h01, 3'h5}, {4'h9, 8'h03, 3'h7}, {4'hA, 8'h21, 3'h4}, {4'hA, 8'h01, 3'h5},
    {4'hF, 8'h01, 3'h7}};
  clcc_cascade #(.W(W), .UPDATE_CYCLES(8)) i_dut (.CLK(CLK), .RST_N(RST_N), .MODE(MODE),
    .SUBMODE(SUBMODE), .TARGET_POS(TARGET_POS), .TARGET_TORQUE(TARGET_TORQUE),
    .RAMP_VEL(RAMP_VEL), .RAMP_ACC(RAMP_ACC), .ACT_POS(ACT_POS), .ACT_VEL(ACT_VEL),
    .ACT_IQ(ACT_IQ), .ACT_ID(ACT_ID), .MAX_SPEED(MAX_SPEED), .MAX_CURRENT(MAX_CURRENT),
    .MAX_PWM(MAX_PWM), .RATED_VOLT(RATED_VOLT), .INERTIA(INERTIA), .GAIN_LEGACY(GAIN_LEGACY),
    .GAIN_NEW(GAIN_NEW), .GAIN_WR(GAIN_WR), .SET_SEL_WR(SET_SEL_WR),
    .SET_SEL_DATA(SET_SEL_DATA), .VEL_FF_FACTOR(VEL_FF_FACTOR), .ACC_FF_FACTOR(ACC_FF_FACTOR),
    .VOLT_FF_FACTOR(VOLT_FF_FACTOR), .FF_WR(FF_WR), .PWM_Q(PWM_Q), .PWM_D(PWM_D),
    .VEL_SETPOINT(VEL_SETPOINT), .CUR_SETPOINT(CUR_SETPOINT), .CLOSED_LOOP(CLOSED_LOOP),
    .POS_ACTIVE(POS_ACTIVE), .VEL_ACTIVE(VEL_ACTIVE), .NEW_SET_ACTIVE(NEW_SET_ACTIVE),
    .UPDATE_TICK(UPDATE_TICK));
  clcc_motor_model #(.W(W)) i_motor (.CLK(CLK), .RST_N(RST_N), .LIVE(live), .PWM_Q(PWM_Q),
    .PWM_D(PWM_D), .ACT_POS(ACT_POS), .ACT_VEL(ACT_VEL), .ACT_IQ(ACT_IQ), .ACT_ID(ACT_ID));
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  task close_out;
    begin
      if (bad_count == 0 && n_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  always @(posedge CLK) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      close_out;
    end
  end
  task check(input [W-1:0] seen, input [W-1:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("FAIL %0t seen %0d expected %0d", $time, $signed(seen), $signed(exp));
      end
    end
  endtask
  function integer sat(input integer v, input integer m);
    sat = (v > m) ? m : ((v < -m) ? -m : v);
  endfunction
  // layout from the top: pos ti, pos kp, vel ti, vel kp, field ti/kp, torque ti/kp
  function [127:0] gains(input [15:0] pkp, input [15:0] pti, input [15:0] vkp);
    gains = {pti, pkp, 16'h0000, vkp, 16'h0000, 16'h0400, 16'h0000, 16'h0400};
  endfunction
  task ticks(input integer n);
    begin
      repeat (n) @(posedge UPDATE_TICK);
      @(negedge CLK);
    end
  endtask
  task pulse(input integer k);
    begin
      @(posedge CLK);
      if (k == 0) FF_WR <= 1'b1;
      else if (k == 1) SET_SEL_WR <= 1'b1;
      else GAIN_WR <= 1'b1;
      @(posedge CLK);
      {FF_WR, SET_SEL_WR, GAIN_WR} <= 3'h0;
    end
  endtask
  task do_reset;
    begin
      RST_N <= 1'b0;
      repeat (4) @(posedge CLK);
      check(PWM_Q, 0);
      check(NEW_SET_ACTIVE, 0);
      RST_N <= 1'b1;
      vf = 0;
      af = 0;
      uf = 1000;
    end
  endtask
  // steady state with frozen feedback and pure proportional stages
  task expect_out(input cl, input po, input ve);
    integer vs, cs, pq;
    begin
      vs = po ? sat(sat(TARGET_POS * pk / 1024, MAX_SPEED) + ((MODE != `CLCC_MODE_CSV) ?
        RAMP_VEL * vf / 1000 : 0), MAX_SPEED) : sat(RAMP_VEL, MAX_SPEED);
      cs = ve ? sat(sat(vs * vk / 1024, MAX_CURRENT) + ((MODE == `CLCC_MODE_PT ||
        MODE == `CLCC_MODE_CST) ? 0 : RAMP_ACC * INERTIA * af / 256000), MAX_CURRENT)
        : sat(TARGET_TORQUE, MAX_CURRENT);
      pq = sat(sat(cs, MAX_PWM) + RATED_VOLT * uf / 1000, MAX_PWM);
      check(VEL_SETPOINT, cl ? vs : 0);
      check(CUR_SETPOINT, cl ? cs : 0);
      check(PWM_Q, cl ? pq : 0);
      check(PWM_D, 0);
    end
  endtask
  task run_mode(input [3:0] m, input [15:0] s, input po, input ve);
    begin
      @(posedge CLK);
      MODE <= m;
      SUBMODE <= s;
      ticks(5);
      expect_out(1'b1, po, ve);
    end
  endtask
  initial begin
    {RST_N, live, GAIN_WR, SET_SEL_WR, SET_SEL_DATA, FF_WR} = 6'h00;
    {bad_count, n_checks, cyc, pk, vk} = {32'h0, 32'h0, 32'h0, 32'h400, 32'h400};
    {MODE, SUBMODE, INERTIA} = {4'h1, 16'h0001, 16'h0100};
    {VEL_FF_FACTOR, ACC_FF_FACTOR, VOLT_FF_FACTOR} = 48'h0;
    {TARGET_POS, TARGET_TORQUE} = {24'h000078, -24'sh000028};
    {RAMP_VEL, RAMP_ACC} = {24'h000046, 24'h00001E};
    {MAX_SPEED, MAX_CURRENT, MAX_PWM, RATED_VOLT} = {23'h3E8, 23'h1F4, 23'h12C, 23'h0};
    GAIN_LEGACY = gains(16'h0400, 16'h0000, 16'h0400);
    GAIN_NEW = 128'h0;
    do_reset;
    for (i = 0; i < 16; i = i + 1) begin
      @(posedge CLK);
      {MODE, SUBMODE[7:0]} <= rows[i][14:3];
      ticks(5);
      check(CLOSED_LOOP, rows[i][2]);
      if (rows[i][2]) check(POS_ACTIVE, rows[i][1]);
      if (rows[i][2]) check(VEL_ACTIVE, rows[i][0]);
      expect_out(rows[i][2], rows[i][1], rows[i][0]);
    end
    RATED_VOLT <= 23'h64;
    run_mode(`CLCC_MODE_PP, 16'h0001, 1'b1, 1'b1);
    {VEL_FF_FACTOR, ACC_FF_FACTOR, VOLT_FF_FACTOR} <= {16'h01F4, 16'h03E8, 16'h0000};
    pulse(0);
    {vf, af, uf} = {32'd500, 32'd1000, 32'd0};
    run_mode(`CLCC_MODE_PP, 16'h0001, 1'b1, 1'b1);
    run_mode(`CLCC_MODE_VEL, 16'h0001, 1'b0, 1'b1);
    run_mode(`CLCC_MODE_CSV, 16'h0003, 1'b1, 1'b1);
    run_mode(`CLCC_MODE_PT, 16'h0001, 1'b0, 1'b1);
    {ACC_FF_FACTOR, VOLT_FF_FACTOR} <= {16'h0000, 16'h01F4};
    pulse(0);
    {af, uf} = {32'd0, 32'd500};
    TARGET_POS <= 24'h001388;
    run_mode(`CLCC_MODE_PP, 16'h0001, 1'b1, 1'b1);
    TARGET_POS <= -24'sh001388;
    run_mode(`CLCC_MODE_PP, 16'h0001, 1'b1, 1'b1);
    TARGET_POS <= 24'h000078;
    GAIN_LEGACY <= gains(16'h0800, 16'h0000, 16'h0200);
    {pk, vk} = {32'd2048, 32'd512};
    run_mode(`CLCC_MODE_PP, 16'h0001, 1'b1, 1'b1);
    SET_SEL_DATA <= 1'b1;
    pulse(1);
    // selector is taken at the edge that ends pulse, the flag one edge later
    repeat (2) @(negedge CLK);
    check(NEW_SET_ACTIVE, 1);
    GAIN_LEGACY <= gains(16'h0400, 16'h0000, 16'h0400);
    run_mode(`CLCC_MODE_PP, 16'h0001, 1'b1, 1'b1);
    GAIN_NEW <= gains(16'h0C00, 16'h0000, 16'h0400);
    pulse(2);
    {pk, vk} = {32'd3072, 32'd1024};
    run_mode(`CLCC_MODE_PP, 16'h0001, 1'b1, 1'b1);
    SET_SEL_DATA <= 1'b0;
    pulse(1);
    pk = 1024;
    run_mode(`CLCC_MODE_PP, 16'h0001, 1'b1, 1'b1);
    GAIN_LEGACY <= gains(16'h0400, 16'h0001, 16'h0400);
    ticks(3);
    v1 = VEL_SETPOINT;
    check(v1 > 155, 1);
    GAIN_LEGACY <= gains(16'h0400, 16'h0002, 16'h0400);
    ticks(2);
    check(VEL_SETPOINT > v1, 1);
    GAIN_LEGACY <= gains(16'h0400, 16'h0000, 16'h0400);
    run_mode(`CLCC_MODE_PP, 16'h0001, 1'b1, 1'b1);
    GAIN_LEGACY <= gains(16'h0400, 16'h0002, 16'h0400);
    ticks(3);
    check(VEL_SETPOINT < v1 && VEL_SETPOINT > 155, 1);
    GAIN_LEGACY <= gains(16'h0400, 16'h0000, 16'h0400);
    live <= 1'b1;
    ticks(20);
    check(CLOSED_LOOP, 1);
    live <= 1'b0;
    SET_SEL_DATA <= 1'b1;
    pulse(1);
    do_reset;
    run_mode(`CLCC_MODE_PP, 16'h0001, 1'b1, 1'b1);
    close_out;
  end
endmodule
